// File: pkg/emac_irq_pkg.sv
`default_nettype none
package emac_irq_pkg;
  // ----------------------------------------------------------------
  // register map (word offsets in bytes)
  // ----------------------------------------------------------------
  localparam logic [7:0] RX_STAT_RAW_OFS    = 8'h00;
  localparam logic [7:0] RX_STAT_MASKED_OFS = 8'h04;
  localparam logic [7:0] RX_MASK_SET_OFS    = 8'h08;
  localparam logic [7:0] RX_MASK_CLEAR_OFS  = 8'h0C;
  localparam logic [7:0] MAC_STAT_RAW_OFS   = 8'h10;
  localparam logic [7:0] MAC_STAT_MSK_OFS   = 8'h14;
  localparam logic [7:0] MAC_MASK_SET_OFS   = 8'h18;
  localparam logic [7:0] MAC_MASK_CLEAR_OFS = 8'h1C;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int RX_CHANNELS     = 8;
  localparam int RX_FRAME_LSB    = 0;
  localparam int RX_THRESH_LSB   = 8;
  localparam int RX_PULSE_LSB    = 16;
  localparam int RX_MASK_WIDTH   = 24;
  localparam int RX_STAT_WIDTH   = 16;
  localparam int MAC_STATS_BIT   = 0;
  localparam int MAC_HOST_BIT    = 1;
  localparam int MAC_WIDTH       = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [23:0] RX_MASK_RST  = 24'h00_0000;
  localparam logic [15:0] RX_STAT_RST  = 16'h0000;
  localparam logic [1:0]  MAC_MASK_RST = 2'h0;
  localparam logic [1:0]  MAC_STAT_RST = 2'h0;
  localparam logic [31:0] RD_ZERO      = 32'h0000_0000;
endpackage : emac_irq_pkg
`default_nettype wire

// File: hdl/emac_interrupt_mask_status.sv
// Operation
// - write-one at 23:16 clears channel pulse enable
// - write-one at 15:8 clears threshold enable
// - write-one at 7:0 clears frame enable
// - clear register reads mask; zero writes ignored
// - bits 31:24 of clear register read zero
// - mac raw bit 1 shows host error flag
// - mac raw bit 0 shows stats flag
// - mac masked bit 1 gated by host enable
// - mac masked bit 0 gated by stats enable
// - mac set bit 1 enables host error
// - mac set bit 0 enables stats
// - mac clear bit 1 disables host error
// - mac clear bit 0 disables stats
// - mac bits 31:2 zero; all reset zero
// - rx set register enables by written ones
// - rx status holds frame and threshold flags
`timescale 1ns/1ps
`default_nettype none
module emac_interrupt_mask_status #(
  parameter int ADDR_W   = 8,
  parameter int CHANNELS = 8
) (
  input  wire logic                mclk,
  input  wire logic                rst_n,
  input  wire logic [ADDR_W-1:0]   regAddr,
  input  wire logic [31:0]         regWrData,
  input  wire logic                regWr,
  input  wire logic                regRd,
  output logic      [31:0]         regRdData,
  input  wire logic [CHANNELS-1:0] rxFrameEvt,
  input  wire logic [CHANNELS-1:0] rxThreshEvt,
  input  wire logic [CHANNELS-1:0] rxPulseEvt,
  input  wire logic                hostErrEvt,
  input  wire logic                statsEvt,
  output logic      [CHANNELS-1:0] rxPulseIrq,
  output logic                     rxIrq,
  output logic                     macIrq
);
  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // field positions are fixed by the register layout
  if (CHANNELS != emac_irq_pkg::RX_CHANNELS)
  begin : g_chan_chk
    $error("CHANNELS must be 8");
  end
  if (ADDR_W < 5 || ADDR_W > 8)
  begin : g_addr_chk
    $error("ADDR_W must be 5 to 8");
  end

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rstSync_q;
  logic       rstN;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rstSync_q <= 2'b00;
    else
      rstSync_q <= {rstSync_q[0], 1'b1};
  end
  assign rstN = rstSync_q[1];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [23:0]         rxMask;
    logic [15:0]         rxStat;
    logic [1:0]          macMask;
    logic [1:0]          macStat;
    logic [31:0]         rdData;
    logic [CHANNELS-1:0] pulse;
  } state_t;

  state_t st_q;
  state_t st_d;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] ofs);
    hit = (8'(a) == ofs);
  endfunction : hit

  // byte address widened to eight bits for decode
  logic [7:0] addr8;
  assign addr8 = 8'(regAddr);

  logic [15:0] rxMasked;
  logic [1:0]  macMasked;
  logic [15:0] rxSetEvt;
  logic [1:0]  macSetEvt;

  // masked view is raw AND each flag's own enable bit
  assign rxMasked  = st_q.rxStat & st_q.rxMask[15:0];
  assign macMasked = st_q.macStat & st_q.macMask;
  assign rxSetEvt  = {rxThreshEvt, rxFrameEvt};
  assign macSetEvt = {hostErrEvt, statsEvt};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_d        = st_q;
    st_d.rdData = emac_irq_pkg::RD_ZERO;
    // read-to-clear status; an event in the same cycle wins
    if (regRd && hit(regAddr, emac_irq_pkg::RX_STAT_RAW_OFS))
      st_d.rxStat = emac_irq_pkg::RX_STAT_RST;
    if (regRd && hit(regAddr, emac_irq_pkg::MAC_STAT_RAW_OFS))
      st_d.macStat = emac_irq_pkg::MAC_STAT_RST;
    st_d.rxStat  = st_d.rxStat | rxSetEvt;
    st_d.macStat = st_d.macStat | macSetEvt;
    if (regWr)
    begin
      case (addr8)
        emac_irq_pkg::RX_MASK_SET_OFS:
          st_d.rxMask = st_q.rxMask | regWrData[23:0];
        emac_irq_pkg::RX_MASK_CLEAR_OFS:
          // bits 31:24 of the write are dropped here
          st_d.rxMask = st_q.rxMask & ~regWrData[23:0];
        emac_irq_pkg::MAC_MASK_SET_OFS:
          st_d.macMask = st_q.macMask | regWrData[1:0];
        emac_irq_pkg::MAC_MASK_CLEAR_OFS:
          st_d.macMask = st_q.macMask & ~regWrData[1:0];
        default:
          st_d.macMask = st_q.macMask;
      endcase
    end
    if (regRd)
    begin
      case (addr8)
        emac_irq_pkg::RX_STAT_RAW_OFS:
          st_d.rdData = {16'h0000, st_q.rxStat};
        emac_irq_pkg::RX_STAT_MASKED_OFS:
          st_d.rdData = {16'h0000, rxMasked};
        emac_irq_pkg::RX_MASK_SET_OFS,
        emac_irq_pkg::RX_MASK_CLEAR_OFS:
          st_d.rdData = {8'h00, st_q.rxMask};
        emac_irq_pkg::MAC_STAT_RAW_OFS:
          st_d.rdData = {30'h0000_0000, st_q.macStat};
        emac_irq_pkg::MAC_STAT_MSK_OFS:
          st_d.rdData = {30'h0000_0000, macMasked};
        emac_irq_pkg::MAC_MASK_SET_OFS,
        emac_irq_pkg::MAC_MASK_CLEAR_OFS:
          st_d.rdData = {30'h0000_0000, st_q.macMask};
        default:
          st_d.rdData = emac_irq_pkg::RD_ZERO;
      endcase
    end
    // pulse interrupts are each event gated by its enable, registered one cycle later
    st_d.pulse = rxPulseEvt & st_q.rxMask[23:16];
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
    begin
      st_q.rxMask  <= emac_irq_pkg::RX_MASK_RST;
      st_q.rxStat  <= emac_irq_pkg::RX_STAT_RST;
      st_q.macMask <= emac_irq_pkg::MAC_MASK_RST;
      st_q.macStat <= emac_irq_pkg::MAC_STAT_RST;
      st_q.rdData  <= emac_irq_pkg::RD_ZERO;
      st_q.pulse   <= '0;
    end
    else
      st_q <= st_d;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign regRdData  = st_q.rdData;
  assign rxPulseIrq = st_q.pulse;
  assign rxIrq      = |rxMasked;
  assign macIrq     = |macMasked;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstN);

  sequence wrAt(logic [7:0] ofs);
    regWr && addr8 == ofs;
  endsequence

  sequence rdAt(logic [7:0] ofs);
    regRd && addr8 == ofs;
  endsequence

  rx_clr_mask_a: assert property (
    wrAt(emac_irq_pkg::RX_MASK_CLEAR_OFS) |=>
      st_q.rxMask == ($past(st_q.rxMask) & ~$past(regWrData[23:0])))
    else $error("rx mask clear wrong");

  rx_set_mask_a: assert property (
    wrAt(emac_irq_pkg::RX_MASK_SET_OFS) |=>
      st_q.rxMask == ($past(st_q.rxMask) | $past(regWrData[23:0])))
    else $error("rx mask set wrong");

  rx_clr_read_a: assert property (
    rdAt(emac_irq_pkg::RX_MASK_CLEAR_OFS) ##1 !regWr |->
      regRdData == {8'h00, $past(st_q.rxMask)})
    else $error("rx clear readback wrong");

  rx_rsvd_zero_a: assert property (
    rdAt(emac_irq_pkg::RX_MASK_CLEAR_OFS) |=> regRdData[31:24] == 8'h00)
    else $error("rx reserved bits nonzero");

  host_raw_a: assert property (
    hostErrEvt ##1 rdAt(emac_irq_pkg::MAC_STAT_RAW_OFS) |=>
      regRdData[1])
    else $error("host flag lost");

  stats_raw_a: assert property (
    statsEvt ##1 rdAt(emac_irq_pkg::MAC_STAT_RAW_OFS) |=>
      regRdData[0])
    else $error("stats flag lost");

  host_masked_a: assert property (
    rdAt(emac_irq_pkg::MAC_STAT_MSK_OFS) |=>
      regRdData[1] == ($past(st_q.macStat[1]) && $past(st_q.macMask[1])))
    else $error("host masked wrong");

  stats_masked_a: assert property (
    rdAt(emac_irq_pkg::MAC_STAT_MSK_OFS) |=>
      regRdData[0] == ($past(st_q.macStat[0]) && $past(st_q.macMask[0])))
    else $error("stats masked wrong");

  mac_set_a: assert property (
    wrAt(emac_irq_pkg::MAC_MASK_SET_OFS) |=>
      st_q.macMask == ($past(st_q.macMask) | $past(regWrData[1:0])))
    else $error("mac mask set wrong");

  mac_clear_a: assert property (
    wrAt(emac_irq_pkg::MAC_MASK_CLEAR_OFS) |=>
      st_q.macMask == ($past(st_q.macMask) & ~$past(regWrData[1:0])))
    else $error("mac mask clear wrong");

  mac_rsvd_a: assert property (
    regRd && addr8 >= emac_irq_pkg::MAC_STAT_RAW_OFS |=>
      regRdData[31:2] == 30'h0000_0000)
    else $error("mac reserved bits nonzero");

  rx_status_a: assert property (
    rxFrameEvt[0] |=> st_q.rxStat[0] ##1
      (st_q.rxStat[0] || $past(regRd && addr8 == emac_irq_pkg::RX_STAT_RAW_OFS)))
    else $error("rx frame flag lost");

  rx_irq_a: assert property (
    rxIrq == |(st_q.rxStat & st_q.rxMask[15:0]))
    else $error("rx irq mismatch");

  mac_irq_a: assert property (
    $rose(macIrq) |-> $past(|macSetEvt) || $past(regWr))
    else $error("mac irq without cause");

  pulse_gate_a: assert property (
    rxPulseEvt[0] && !st_q.rxMask[16] |=> !rxPulseIrq[0])
    else $error("masked pulse leaked");

  // ----------------------------------------------------------------
  // read path and flag lifetime checks
  // ----------------------------------------------------------------
  // a set flag that no raw read touches this cycle
  sequence hostKept;
    st_q.macStat[1] && !(regRd && addr8 == emac_irq_pkg::MAC_STAT_RAW_OFS);
  endsequence

  sequence statsKept;
    st_q.macStat[0] && !(regRd && addr8 == emac_irq_pkg::MAC_STAT_RAW_OFS);
  endsequence

  host_sticky_a: assert property (
    hostKept |=> st_q.macStat[1])
    else $error("host flag dropped");

  stats_sticky_a: assert property (
    statsKept |=> st_q.macStat[0])
    else $error("stats flag dropped");

  host_set_a: assert property (
    hostErrEvt |=> st_q.macStat[1])
    else $error("host event not latched");

  stats_set_a: assert property (
    statsEvt |=> st_q.macStat[0])
    else $error("stats event not latched");

  thresh_set_a: assert property (
    rxThreshEvt[7] |=> st_q.rxStat[15])
    else $error("threshold event not latched");

  frame_set_a: assert property (
    rxFrameEvt[7] |=> st_q.rxStat[7])
    else $error("frame event not latched");

  rx_raw_read_a: assert property (
    rdAt(emac_irq_pkg::RX_STAT_RAW_OFS) |=>
      regRdData == {16'h0000, $past(st_q.rxStat)})
    else $error("rx raw read wrong");

  rx_masked_read_a: assert property (
    rdAt(emac_irq_pkg::RX_STAT_MASKED_OFS) |=>
      regRdData == {16'h0000, $past(st_q.rxStat) & $past(st_q.rxMask[15:0])})
    else $error("rx masked read wrong");

  mac_raw_read_a: assert property (
    rdAt(emac_irq_pkg::MAC_STAT_RAW_OFS) |=>
      regRdData[1:0] == $past(st_q.macStat))
    else $error("mac raw read wrong");

  rx_raw_clear_a: assert property (
    regRd && addr8 == emac_irq_pkg::RX_STAT_RAW_OFS && !(|rxSetEvt) |=>
      st_q.rxStat == 16'h0000)
    else $error("rx raw read did not clear");

  mac_raw_clear_a: assert property (
    regRd && addr8 == emac_irq_pkg::MAC_STAT_RAW_OFS && !(|macSetEvt) |=>
      st_q.macStat == 2'h0)
    else $error("mac raw read did not clear");

  rx_clr_zero_a: assert property (
    regWr && addr8 == emac_irq_pkg::RX_MASK_CLEAR_OFS && regWrData[23:0] == 24'h00_0000 |=>
      $stable(st_q.rxMask))
    else $error("zero clear write moved mask");

  unmapped_zero_a: assert property (
    regRd && addr8 > emac_irq_pkg::MAC_MASK_CLEAR_OFS |=>
      regRdData == 32'h0000_0000)
    else $error("unmapped read nonzero");

  rd_idle_a: assert property (
    !regRd |=> regRdData == 32'h0000_0000)
    else $error("read data outside read slot");

  rx_mask_hold_a: assert property (
    !regWr |=> $stable(st_q.rxMask))
    else $error("rx mask moved without write");

  mac_mask_hold_a: assert property (
    !regWr |=> $stable(st_q.macMask))
    else $error("mac mask moved without write");

  pulse_pass_a: assert property (
    rxPulseEvt[1] && st_q.rxMask[17] |=> rxPulseIrq[1])
    else $error("enabled pulse lost");

  pulse_once_a: assert property (
    !(|rxPulseEvt) |=> rxPulseIrq == '0)
    else $error("pulse without source");

  rx_irq_rise_a: assert property (
    $rose(rxIrq) |-> $past(|rxSetEvt) || $past(regWr))
    else $error("rx irq without cause");

  rx_irq_fall_a: assert property (
    $fell(rxIrq) |-> $past(regRd) || $past(regWr))
    else $error("rx irq dropped without cause");

  mac_irq_fall_a: assert property (
    $fell(macIrq) |-> $past(regRd) || $past(regWr))
    else $error("mac irq dropped without cause");

endmodule : emac_interrupt_mask_status
`default_nettype wire

// File: test/emac_interrupt_mask_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
module emac_interrupt_mask_status_tb;
  typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d;} row_t;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0000_0000;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [31:0] regRdData;
  logic [7:0]  rxFrameEvt = 8'h00;
  logic [7:0]  rxThreshEvt = 8'h00;
  logic [7:0]  rxPulseEvt = 8'h00;
  logic        hostErrEvt = 1'b0;
  logic        statsEvt = 1'b0;
  logic [7:0]  rxPulseIrq;
  logic        rxIrq;
  logic        macIrq;
  int          nErrors = 0;
  int          testsRun = 0;
  row_t        rows [0:15];

  emac_interrupt_mask_status dut (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .rxFrameEvt(rxFrameEvt), .rxThreshEvt(rxThreshEvt), .rxPulseEvt(rxPulseEvt),
    .hostErrEvt(hostErrEvt), .statsEvt(statsEvt), .rxPulseIrq(rxPulseIrq),
    .rxIrq(rxIrq), .macIrq(macIrq));

  always #4 mclk = ~mclk;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp)
    begin
      nErrors++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe, so sample mid-cycle there
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    @(negedge mclk);
    chk($sformatf("read %h", a), regRdData, exp);
  endtask : rd

  task automatic evt(input logic [7:0] f, input logic [7:0] t, input logic [7:0] p,
                     input logic h, input logic s);
    @(posedge mclk);
    {rxFrameEvt, rxThreshEvt, rxPulseEvt, hostErrEvt, statsEvt} <= {f, t, p, h, s};
    @(posedge mclk);
    {rxFrameEvt, rxThreshEvt, rxPulseEvt, hostErrEvt, statsEvt} <= '0;
    @(negedge mclk);
  endtask : evt

  task automatic tally_and_finish;
    $display("errors %0d checks %0d", nErrors, testsRun);
    if (nErrors == 0 && testsRun > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    repeat (3000) @(posedge mclk);
    nErrors++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rows = '{
      '{1'b0, 8'h08, 32'h0000_0000},
      '{1'b1, 8'h08, 32'hFFFF_FFFF},
      '{1'b0, 8'h0C, 32'h00FF_FFFF},
      '{1'b1, 8'h0C, 32'h0000_0000},
      '{1'b0, 8'h08, 32'h00FF_FFFF},
      '{1'b1, 8'h0C, 32'hFFA5_0000},
      '{1'b1, 8'h0C, 32'h0000_3C00},
      '{1'b1, 8'h0C, 32'h0000_00F0},
      '{1'b0, 8'h0C, 32'h005A_C30F},
      '{1'b1, 8'h18, 32'hFFFF_FFFD},
      '{1'b0, 8'h1C, 32'h0000_0001},
      '{1'b1, 8'h18, 32'h0000_0002},
      '{1'b1, 8'h1C, 32'hFFFF_FFFC},
      '{1'b0, 8'h18, 32'h0000_0003},
      '{1'b1, 8'h10, 32'hFFFF_FFFF},
      '{1'b0, 8'h20, 32'h0000_0000}};
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    for (int i = 0; i < 16; i++)
      if (rows[i].wr)
        wr(rows[i].a, rows[i].d);
      else
        rd(rows[i].a, rows[i].d);
    rd(8'h14, 32'h0000_0000);
    chk("macIrq idle", {31'h0, macIrq}, 32'h0000_0000);
    // stats enabled, host disabled
    wr(8'h1C, 32'h0000_0002);
    evt(8'h00, 8'h00, 8'h00, 1'b0, 1'b1);
    chk("macIrq stats", {31'h0, macIrq}, 32'h0000_0001);
    rd(8'h14, 32'h0000_0001);
    rd(8'h10, 32'h0000_0001);
    chk("macIrq cleared", {31'h0, macIrq}, 32'h0000_0000);
    evt(8'h00, 8'h00, 8'h00, 1'b1, 1'b0);
    chk("macIrq masked", {31'h0, macIrq}, 32'h0000_0000);
    rd(8'h14, 32'h0000_0000);
    wr(8'h18, 32'h0000_0002);
    rd(8'h14, 32'h0000_0002);
    rd(8'h10, 32'h0000_0002);
    rd(8'h10, 32'h0000_0000);
    // events beside a raw read survive its clear; the next read sees them
    @(posedge mclk);
    {hostErrEvt, statsEvt} <= 2'b11;
    regRd <= 1'b1;
    regAddr <= 8'h10;
    @(posedge mclk);
    {hostErrEvt, statsEvt} <= 2'b00;
    @(negedge mclk);
    chk("raw beside event", regRdData, 32'h0000_0000);
    @(posedge mclk);
    regRd <= 1'b0;
    @(negedge mclk);
    chk("raw after event", regRdData, 32'h0000_0003);
    chk("macIrq after clear", {31'h0, macIrq}, 32'h0000_0000);
    wr(8'h08, 32'h0000_0000);
    rd(8'h08, 32'h005A_C30F);
    // rx group, mask left at 005A_C30F
    evt(8'hFF, 8'hFF, 8'h00, 1'b0, 1'b0);
    chk("rxIrq set", {31'h0, rxIrq}, 32'h0000_0001);
    rd(8'h04, 32'h0000_C30F);
    rd(8'h00, 32'h0000_FFFF);
    chk("rxIrq cleared", {31'h0, rxIrq}, 32'h0000_0000);
    evt(8'h00, 8'h00, 8'hFF, 1'b0, 1'b0);
    chk("pulse gated", {24'h0, rxPulseIrq}, 32'h0000_005A);
    @(negedge mclk);
    chk("pulse ends", {24'h0, rxPulseIrq}, 32'h0000_0000);
    // reset in mid-run drops every mask
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(8'h0C, 32'h0000_0000);
    rd(8'h1C, 32'h0000_0000);
    rd(8'h14, 32'h0000_0000);
    tally_and_finish();
  end
endmodule : emac_interrupt_mask_status_tb
`default_nettype wire
